/* rtl/qdr_pkg.sv */
// qdr_pkg: constants, state codes and latency decoding of the read engine
`default_nettype none
package qdr_pkg;
	// register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] REG_CONFIG     = 8'h00;
	localparam logic [7:0] REG_PREAMBLE   = 8'h04;
	localparam logic [7:0] REG_STATUS     = 8'h08;
	localparam logic [7:0] REG_MEM_PTR    = 8'h0C;
	localparam logic [7:0] REG_MEM_DATA   = 8'h10;
	// config_reg_one field positions, reset values of config_reg_one and learning_preamble
	localparam int         CFG_EXT_ADDR   = 0;
	localparam int         CFG_FOUR_LANE  = 1;
	localparam int         CFG_LC_LO      = 2;
	localparam int         CFG_ENH_TABLE  = 4;
	localparam int         CFG_DLP_EN     = 5;
	localparam logic [7:0] CONFIG_RESET   = 8'h00;
	localparam logic [7:0] PREAMBLE_RESET = 8'h34;
	// status field positions
	localparam int         STS_CONT_QUAD  = 0;
	localparam int         STS_CONT_DDR   = 1;
	localparam int         STS_BUSY       = 2;
	localparam int         STS_MODE_LO    = 8;
	// command opcodes and the mode nibble that keeps four-lane continuous mode
	localparam logic [7:0] OP_FOUR_LANE_READ      = 8'hEB;
	localparam logic [7:0] OP_FOUR_LANE_READ_LONG = 8'hEC;
	localparam logic [7:0] OP_DDR_FAST_READ       = 8'h0D;
	localparam logic [7:0] OP_DDR_FAST_READ_LONG  = 8'h0E;
	localparam logic [3:0] MODE_KEEP_NIBBLE       = 4'hA;
	// phase lengths, in units counted by the sequencer (last index)
	localparam logic [5:0] OPCODE_LAST     = 6'h07;
	localparam logic [5:0] ADDR3_QUAD_LAST = 6'h05;
	localparam logic [5:0] ADDR4_QUAD_LAST = 6'h07;
	localparam logic [5:0] ADDR3_DDR_LAST  = 6'h17;
	localparam logic [5:0] ADDR4_DDR_LAST  = 6'h1F;
	localparam logic [5:0] MODE_QUAD_LAST  = 6'h01;
	localparam logic [5:0] MODE_DDR_LAST   = 6'h07;
	localparam logic [6:0] PREAMBLE_EDGES  = 7'h08;
	// dummy cycles per latency code
	localparam logic [5:0] QUAD_DUMMY_LC0  = 6'h08;
	localparam logic [5:0] QUAD_DUMMY_LC1  = 6'h04;
	localparam logic [5:0] QUAD_DUMMY_LC2  = 6'h05;
	localparam logic [5:0] QUAD_DUMMY_LC3  = 6'h06;
	localparam logic [5:0] DDRP_DUMMY_LC0  = 6'h06;
	localparam logic [5:0] DDRP_DUMMY_LC1  = 6'h05;
	localparam logic [5:0] DDRP_DUMMY_LC2  = 6'h06;
	localparam logic [5:0] DDRP_DUMMY_LC3  = 6'h07;
	localparam logic [5:0] DDRE_DUMMY_LC0  = 6'h08;
	localparam logic [5:0] DDRE_DUMMY_LC1  = 6'h05;
	localparam logic [5:0] DDRE_DUMMY_LC2  = 6'h06;
	localparam logic [5:0] DDRE_DUMMY_LC3  = 6'h07;
	// AXI responses
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;

	typedef enum logic [6:0] {
		QDR_IDLE   = 7'h01,
		QDR_OPCODE = 7'h02,
		QDR_ADDR   = 7'h04,
		QDR_MODE   = 7'h08,
		QDR_DUMMY  = 7'h10,
		QDR_DATA   = 7'h20,
		QDR_IGNORE = 7'h40
	} qdr_state_t;

	// dummy cycles from latency code; quad reads share one table
	function automatic logic [5:0] qdr_dummy(input logic [1:0] lc, input logic ddr,
		input logic enh);
		logic [5:0] d;
		d = QUAD_DUMMY_LC0;
		unique case ({ddr, enh, lc})
			4'h0, 4'h4: d = QUAD_DUMMY_LC0;
			4'h1, 4'h5: d = QUAD_DUMMY_LC1;
			4'h2, 4'h6: d = QUAD_DUMMY_LC2;
			4'h3, 4'h7: d = QUAD_DUMMY_LC3;
			4'h8:       d = DDRP_DUMMY_LC0;
			4'h9:       d = DDRP_DUMMY_LC1;
			4'hA:       d = DDRP_DUMMY_LC2;
			4'hB:       d = DDRP_DUMMY_LC3;
			4'hC:       d = DDRE_DUMMY_LC0;
			4'hD:       d = DDRE_DUMMY_LC1;
			4'hE:       d = DDRE_DUMMY_LC2;
			4'hF:       d = DDRE_DUMMY_LC3;
		endcase
		return d;
	endfunction : qdr_dummy
endpackage : qdr_pkg
`default_nettype wire

/* rtl/qdr_read_engine.sv */
// qdr_read_engine: four-lane and double-rate read engine with AXI4-Lite control
`default_nettype none
module qdr_read_engine
	import qdr_pkg::*;
#(
	parameter int MEM_AW   = 10,
	parameter int FLASH_AW = 24
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output var  logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output var  logic        wready,
	output var  logic [1:0]  bresp,
	output var  logic        bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output var  logic        arready,
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	output var  logic        rvalid,
	input  wire logic        rready,
	input  wire logic        sck,
	input  wire logic        chip_select_n,
	input  wire logic        pause_n,
	input  wire logic [3:0]  quad_data_in,
	output var  logic [3:0]  quad_data_out,
	output var  logic [3:0]  quad_data_oe
);
	localparam int          MEM_DEPTH = 1 << MEM_AW;
	localparam logic [31:0] ADDR_MASK = (FLASH_AW >= 32) ? 32'hFFFFFFFF :
		32'((64'h1 << FLASH_AW) - 64'h1);

	// decode shared by the read and the write side of the bus
	function automatic logic reg_known(input logic [7:0] a);
		return (a == REG_CONFIG) || (a == REG_PREAMBLE) || (a == REG_STATUS) ||
			(a == REG_MEM_PTR) || (a == REG_MEM_DATA);
	endfunction : reg_known

	// pin synchronisers and edge history
	logic        sck_m;
	logic        sck_s;
	logic        sck_d;
	logic        cs_m;
	logic        cs_s;
	logic        cs_d;
	logic        pause_m;
	logic        pause_s;
	logic [3:0]  io_m;
	logic [3:0]  io_s;

	// software-visible state
	logic [7:0]        config_reg_one;
	logic [7:0]        learning_preamble;
	logic [MEM_AW-1:0] mem_ptr;
	logic [7:0]        mem [0:MEM_DEPTH-1];

	// sequencer state
	qdr_state_t  st;
	logic [5:0]  cnt;
	logic [6:0]  eleft;
	logic [2:0]  bidx;
	logic        ddr;
	logic        long_addr;
	logic        mode_done;
	logic [7:0]  op_sr;
	logic [7:0]  mode_sr;
	logic [31:0] addr;
	logic        cont_quad;
	logic        cont_ddr;

	// bus slave state
	logic        aw_have;
	logic        w_have;
	logic [7:0]  wr_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// two flops on every pin before any logic looks at it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_m   <= 1'b0;
			sck_s   <= 1'b0;
			cs_m    <= 1'b1;
			cs_s    <= 1'b1;
			pause_m <= 1'b1;
			pause_s <= 1'b1;
			io_m    <= 4'h0;
			io_s    <= 4'h0;
		end else begin
			sck_m   <= sck;
			sck_s   <= sck_m;
			cs_m    <= chip_select_n;
			cs_s    <= cs_m;
			pause_m <= pause_n;
			pause_s <= pause_m;
			io_m    <= quad_data_in;
			io_s    <= io_m;
		end
	end

	// history flops read only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_d <= 1'b0;
			cs_d  <= 1'b1;
		end else begin
			sck_d <= sck_s;
			cs_d  <= cs_s;
		end
	end

	// edge events, only counted while selected
	logic sck_rise;
	logic sck_fall;
	logic any_edge;
	logic cs_rise;
	assign sck_rise = sck_s & ~sck_d & ~cs_s;
	assign sck_fall = ~sck_s & sck_d & ~cs_s;
	assign any_edge = sck_rise | sck_fall;
	assign cs_rise  = cs_s & ~cs_d;

	// config fields
	logic       ext_addr_mode;
	logic       four_lane_enable;
	logic [1:0] latency_code_bits;
	logic       enhanced_latency_table;
	logic       preamble_en;
	assign ext_addr_mode          = config_reg_one[CFG_EXT_ADDR];
	assign four_lane_enable       = config_reg_one[CFG_FOUR_LANE];
	assign latency_code_bits      = config_reg_one[CFG_LC_LO +: 2];
	assign enhanced_latency_table = config_reg_one[CFG_ENH_TABLE];
	assign preamble_en            = config_reg_one[CFG_DLP_EN];

	// opcode decode on the last opcode bit
	logic [7:0] next_op;
	logic       quad_op;
	logic       ddr_op;
	logic       op_long;
	assign next_op = {op_sr[6:0], io_s[0]};
	assign quad_op = (next_op == OP_FOUR_LANE_READ) || (next_op == OP_FOUR_LANE_READ_LONG);
	assign ddr_op  = (next_op == OP_DDR_FAST_READ) || (next_op == OP_DDR_FAST_READ_LONG);
	assign op_long = (next_op == OP_FOUR_LANE_READ_LONG) ||
		(next_op == OP_DDR_FAST_READ_LONG) || ext_addr_mode;

	// per-phase event and length selection
	logic       in_ev;
	logic       out_ev;
	logic       addr_ev;
	logic       pause_hold;
	logic       has_mode;
	logic [5:0] addr_last;
	logic [5:0] mode_last;
	logic [5:0] dummy_cnt;
	logic [6:0] eleft_load;
	assign in_ev      = ddr ? any_edge : sck_rise;
	assign out_ev     = ddr ? any_edge : sck_fall;
	// the fall closing the last opcode cycle is no address bit; address starts on a rise
	assign addr_ev    = in_ev & ~(ddr & sck_fall & (cnt == 6'h00));
	// pause only freezes the shared opcode phase; address, mode, dummy and data phases never look at it
	assign pause_hold = ~pause_s & (st == QDR_OPCODE);
	assign has_mode   = ~ddr | enhanced_latency_table;
	assign addr_last  = ddr ? (long_addr ? ADDR4_DDR_LAST : ADDR3_DDR_LAST) :
		(long_addr ? ADDR4_QUAD_LAST : ADDR3_QUAD_LAST);
	assign mode_last  = ddr ? MODE_DDR_LAST : MODE_QUAD_LAST;
	assign dummy_cnt  = qdr_dummy(latency_code_bits, ddr, enhanced_latency_table);
	// double-rate dummy counts every edge up to the last dummy rise
	assign eleft_load = ddr ? (7'({dummy_cnt, 1'b0}) - 7'h01) : {1'b0, dummy_cnt};

	// data path: byte under the address counter and wrapped successor
	logic [7:0]  rd_byte;
	logic [3:0]  rd_nibble;
	logic [31:0] addr_inc;
	logic        byte_end;
	logic [2:0]  bstep;
	assign rd_byte   = mem[addr[MEM_AW-1:0]];
	assign rd_nibble = bidx[2] ? rd_byte[7:4] : rd_byte[3:0];
	assign addr_inc  = (addr + 32'h00000001) & ADDR_MASK;
	assign bstep     = ddr ? 3'h1 : 3'h4;
	assign byte_end  = ddr ? (bidx == 3'h0) : (bidx == 3'h3);

	// preamble: last eight edges before the first data edge
	logic dlp_drive;
	logic dlp_bit;
	assign dlp_drive = (st == QDR_DUMMY) & ddr & preamble_en & any_edge &
		(eleft <= PREAMBLE_EDGES);
	assign dlp_bit   = learning_preamble[3'(eleft - 7'h01)];

	// mode byte decisions for the next frame
	logic keep_quad;
	logic keep_ddr;
	assign keep_quad = mode_done & ~ddr & (mode_sr[7:4] == MODE_KEEP_NIBBLE);
	assign keep_ddr  = mode_done & ddr & (mode_sr[7:4] == ~mode_sr[3:0]);

	// command sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn || cs_s) begin
			st        <= QDR_IDLE;
			cnt       <= 6'h00;
			mode_done <= 1'b0;
			eleft     <= 7'h00;
			bidx      <= 3'h7;
			op_sr     <= 8'h00;
			if (!aresetn) begin
				ddr       <= 1'b0;
				long_addr <= 1'b0;
				mode_sr   <= 8'h00;
				addr      <= 32'h00000000;
			end
		end else begin
			unique case (st)
				QDR_IDLE: begin
					// continuous mode skips the opcode entirely
					cnt  <= 6'h00;
					addr <= 32'h00000000;
					if (cont_quad || cont_ddr) begin
						st  <= QDR_ADDR;
						ddr <= cont_ddr;
					end else begin
						st <= QDR_OPCODE;
					end
				end
				QDR_OPCODE: begin
					if (sck_rise && !pause_hold) begin
						op_sr <= next_op;
						cnt   <= cnt + 6'h01;
						if (cnt == OPCODE_LAST) begin
							cnt       <= 6'h00;
							long_addr <= op_long;
							if (quad_op && four_lane_enable) begin
								st  <= QDR_ADDR;
								ddr <= 1'b0;
							end else if (ddr_op) begin
								st  <= QDR_ADDR;
								ddr <= 1'b1;
							end else begin
								st <= QDR_IGNORE;
							end
						end
					end
				end
				QDR_ADDR: begin
					if (addr_ev) begin
						addr <= ddr ? {addr[30:0], io_s[0]} : {addr[27:0], io_s};
						cnt  <= cnt + 6'h01;
						if (cnt == addr_last) begin
							cnt   <= 6'h00;
							eleft <= eleft_load;
							st    <= has_mode ? QDR_MODE : QDR_DUMMY;
						end
					end
				end
				QDR_MODE: begin
					if (in_ev) begin
						mode_sr <= ddr ? {mode_sr[6:0], io_s[0]} : {mode_sr[3:0], io_s};
						cnt     <= cnt + 6'h01;
						if (cnt == mode_last) begin
							mode_done <= 1'b1;
							st        <= QDR_DUMMY;
						end
					end
				end
				QDR_DUMMY: begin
					// line values are not looked at while counting
					if (in_ev) begin
						eleft <= eleft - 7'h01;
						if (eleft == 7'h01) begin
							st   <= QDR_DATA;
							bidx <= 3'h7;
						end
					end
				end
				QDR_DATA: begin
					if (out_ev) begin
						bidx <= bidx - bstep;
						if (byte_end) begin
							addr <= addr_inc;
						end
					end
				end
				QDR_IGNORE: begin
					cnt <= 6'h00;
				end
			endcase
		end
	end

	// continuous modes are decided at each select rise; a frame that never
	// finished its mode byte (short pulse, invalid opcode) always drops out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cont_quad <= 1'b0;
			cont_ddr  <= 1'b0;
		end else if (cs_rise) begin
			cont_quad <= keep_quad;
			cont_ddr  <= keep_ddr;
		end
	end

	// pin drivers; released on the cycle after the synchronised select reads high
	always_ff @(posedge aclk) begin
		if (!aresetn || cs_s) begin
			quad_data_out <= 4'h0;
			quad_data_oe  <= 4'h0;
		end else if (st == QDR_DATA && out_ev) begin
			quad_data_out <= ddr ? {2'h0, rd_byte[bidx], 1'b0} : rd_nibble;
			quad_data_oe  <= ddr ? 4'h2 : 4'hF;
		end else if (dlp_drive) begin
			quad_data_out <= {2'h0, dlp_bit, 1'b0};
			quad_data_oe  <= 4'h2;
		end
	end

	// write channel bookkeeping: address and data in either order
	logic aw_take;
	logic w_take;
	logic wr_do;
	logic next_aw_have;
	logic next_w_have;
	assign aw_take      = awvalid & awready;
	assign w_take       = wvalid & wready;
	assign wr_do        = aw_have & w_have & ~bvalid;
	assign next_aw_have = (aw_have | aw_take) & ~wr_do;
	assign next_w_have  = (w_have | w_take) & ~wr_do;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			w_have  <= 1'b0;
			awready <= 1'b0;
			wready  <= 1'b0;
			wr_addr <= 8'h00;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
		end else begin
			aw_have <= next_aw_have;
			w_have  <= next_w_have;
			awready <= ~next_aw_have;
			wready  <= ~next_w_have;
			if (aw_take) wr_addr <= awaddr;
			if (w_take) begin
				w_data <= wdata;
				w_strb <= wstrb;
			end
		end
	end

	// write response; unmapped offsets answer SLVERR and change nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (wr_do) begin
			bvalid <= 1'b1;
			bresp  <= reg_known(wr_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// register stores; gated by the lane 0 strobe alone, though the pointer also takes its upper bits from lane 1
	logic wr_lane0;
	assign wr_lane0 = wr_do & w_strb[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			config_reg_one    <= CONFIG_RESET;
			learning_preamble <= PREAMBLE_RESET;
			mem_ptr           <= '0;
		end else if (wr_lane0) begin
			if (wr_addr == REG_CONFIG) config_reg_one <= w_data[7:0];
			if (wr_addr == REG_PREAMBLE) learning_preamble <= w_data[7:0];
			if (wr_addr == REG_MEM_PTR) mem_ptr <= w_data[MEM_AW-1:0];
			if (wr_addr == REG_MEM_DATA) mem_ptr <= mem_ptr + MEM_AW'(1);
		end
	end

	// array load port; the flash side only reads it
	always_ff @(posedge aclk) begin
		if (wr_lane0 && wr_addr == REG_MEM_DATA) begin
			mem[mem_ptr] <= w_data[7:0];
		end
	end

	// read mux
	logic [31:0] status_word;
	logic [31:0] rd_word;
	logic        ar_take;
	logic        next_rvalid;
	assign status_word = {16'h0000, mode_sr, 5'h00, ~cs_s, cont_ddr, cont_quad};
	assign rd_word = (araddr == REG_CONFIG)   ? {24'h000000, config_reg_one} :
		(araddr == REG_PREAMBLE) ? {24'h000000, learning_preamble} :
		(araddr == REG_STATUS)   ? status_word :
		(araddr == REG_MEM_PTR)  ? 32'(mem_ptr) :
		(araddr == REG_MEM_DATA) ? {24'h000000, mem[mem_ptr]} : 32'h00000000;
	assign ar_take     = arvalid & arready;
	assign next_rvalid = ar_take | (rvalid & ~rready);

	// read channel: one read in flight, answer one cycle after the take
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= RESP_OKAY;
		end else begin
			arready <= ~next_rvalid;
			rvalid  <= next_rvalid;
			if (ar_take) begin
				rdata <= rd_word;
				rresp <= reg_known(araddr) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end
endmodule : qdr_read_engine
`default_nettype wire

/* sim/qdr_host_model.sv */
// qdr_host_model: host flash controller driving sck, select and the data lines
`default_nettype none
module qdr_host_model (
	output var logic       sck,
	output var logic       chip_select_n,
	output var logic [3:0] quad_data_in,
	input wire logic [3:0] quad_data_out,
	input wire logic [3:0] quad_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hv;
	logic [3:0] hm;
	logic       flt;
	logic [3:0] cap;
	logic       seen;

	// line level: device first, then host; no pulls, so a free line toggles
	always_comb for (int i = 0; i < 4; i++)
		quad_data_in[i] = quad_data_oe[i] ? quad_data_out[i] : hm[i] ? hv[i] : flt;

	// idle: not selected, clock parked low
	initial begin
		sck = 1'b0;
		chip_select_n = 1'b1;
		{hv, hm, flt, cap, seen} = '0;
	end

	// half period: lines set 50 ns before the edge, sampled 40 ns after it
	task automatic hp(input logic [3:0] v, input logic [3:0] m);
		hv = v;
		hm = m;
		flt = ~flt;
		#50 sck = ~sck; // 5 MHz, far under both ceilings
		#40 cap = quad_data_in;
		seen = seen | (|quad_data_oe);
		#10;
	endtask : hp

	// one frame; an address bytes, mn mode present, d dummy cycles, nb bytes read
	task automatic frame(input logic oen, input logic [7:0] op, input logic ddr,
		input int an, input logic [31:0] a, input logic mn, input logic [7:0] md,
		input int d, input int nb, output logic [7:0] pre, output logic [31:0] dat);
		pre = 8'h00;
		dat = 32'h0;
		seen = 1'b0;
		#7 chip_select_n = 1'b0;
		#100;
		if (oen) for (int i = 7; i >= 0; i--) repeat (2) hp({3'h0, op[i]}, 4'h1);
		if (ddr) for (int i = an * 8 - 1; i >= 0; i--) hp({3'h0, a[i]}, 4'h1);
		else for (int i = an * 2 - 1; i >= 0; i--) repeat (2) hp(a[i*4+:4], 4'hF);
		if (mn && ddr) for (int i = 7; i >= 0; i--) hp({3'h0, md[i]}, 4'h1);
		if (mn && !ddr) for (int i = 1; i >= 0; i--) repeat (2) hp(md[i*4+:4], 4'hF);
		// lines released through all dummy cycles, so a preamble can be driven
		repeat (d * 2) begin
			hp(4'h0, 4'h0);
			pre = {pre[6:0], cap[1]};
		end
		repeat (nb * (ddr ? 8 : 4)) begin
			hp(4'h0, 4'h0);
			if (ddr) dat = {dat[30:0], cap[1]};
			else if (sck) dat = {dat[27:0], cap};
		end
		#100 chip_select_n = 1'b1; // select held low through mode and dummy
		#300;
	endtask : frame
endmodule : qdr_host_model
`default_nettype wire

/* sim/qdr_read_engine_assertions.sv */
// qdr_read_engine_assertions: port checks of the read engine
`default_nettype none
module qdr_read_engine_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic        sck,
	input wire logic        chip_select_n,
	input wire logic [3:0]  quad_data_out,
	input wire logic [3:0]  quad_data_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic       sck_q;
	logic [3:0] edge_age;
	logic [3:0] fall_age;

	// cycles since the last sck edge and fall; saturating keeps idle gaps harmless
	always_ff @(posedge aclk) begin
		sck_q <= sck;
		edge_age <= (!aresetn || sck != sck_q) ? 4'h0 : edge_age + 4'(edge_age != 4'hF);
		fall_age <= (!aresetn || (sck_q && !sck)) ? 4'h0 : fall_age + 4'(fall_age != 4'hF);
	end

	// address and data taken at one edge
	sequence wr_both;
		awvalid && awready && wvalid && wready;
	endsequence

	AST_OUT_QUAD: assert property (
		!chip_select_n && quad_data_oe == 4'hF && $past(quad_data_oe) == 4'hF
		&& $changed(quad_data_out) |-> fall_age <= 4'h5)
		else $error("four-lane nibble changed away from an sck fall");
	AST_OUT_DDR: assert property (
		!chip_select_n && quad_data_oe == 4'h2 && $past(quad_data_oe) == 4'h2
		&& $changed(quad_data_out[1]) |-> edge_age <= 4'h5)
		else $error("double-rate bit changed away from an sck edge");
	AST_OE_START: assert property (
		$rose(quad_data_oe != 4'h0) |-> fall_age <= 4'h5)
		else $error("output drive began away from an sck fall");
	AST_OE_SHAPE: assert property (
		quad_data_oe == 4'h0 || quad_data_oe == 4'h2 || quad_data_oe == 4'hF)
		else $error("output enables form no legal lane set");
	AST_OE_IDLE: assert property (
		chip_select_n [*6] |-> quad_data_oe == 4'h0)
		else $error("lines driven while not selected");
	AST_WRITE_RESP: assert property (wr_both |-> ##[2:3] bvalid)
		else $error("write response late");
	AST_BVALID_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before taken");
	AST_RVALID_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before taken");
	AST_READ_RESP: assert property (arvalid && arready |-> ##[1:2] rvalid)
		else $error("read response late");
endmodule : qdr_read_engine_assertions
`default_nettype wire

/* sim/test_quad_io_and_ddr_read_engine.sv */
// test_quad_io_and_ddr_read_engine: bench for the read engine, registers and link
`default_nettype none
module test_quad_io_and_ddr_read_engine
	import qdr_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        sck;
	logic        chip_select_n;
	logic        pause_n;
	logic [3:0]  quad_data_in;
	logic [3:0]  quad_data_out;
	logic [3:0]  quad_data_oe;
	logic [7:0]  pre_got;
	logic [31:0] dat_got;
	int          err_total;
	int          tests_run;
	int          cyc;
	int          qd[4] = '{8, 4, 5, 6}; // four-lane dummy cycles per latency code

	qdr_read_engine #(.MEM_AW(10), .FLASH_AW(24)) qdr_read_engine_inst (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .sck, .chip_select_n, .pause_n, .quad_data_in, .quad_data_out,
		.quad_data_oe
	);
	qdr_host_model qdr_host_model_inst (
		.sck, .chip_select_n, .quad_data_in, .quad_data_out, .quad_data_oe
	);

	// 40 MHz system clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// hang guard, well above the few thousand cycles the run needs
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	// array byte as loaded; low ten address bits pick it
	function automatic logic [7:0] mv(input logic [31:0] i);
		return 8'(i[9:0] * 37 + 11);
	endfunction : mv

	// register write; address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk_val({30'h0, bresp}, {30'h0, er});
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk_val(rdata, ex);
		chk_val({30'h0, rresp}, {30'h0, er});
	endtask : axi_rd

	// two-byte read frame, judged against the array from the start address on
	task automatic rd(input logic oen, input logic [7:0] op, input logic ddr, input int an,
		input logic [31:0] a, input logic mn, input logic [7:0] md, input int d);
		qdr_host_model_inst.frame(oen, op, ddr, an, a, mn, md, d, 2, pre_got, dat_got);
		chk_val(dat_got, {16'h0, mv(a), mv(a + 1)});
	endtask : rd

	task automatic t_regs();
		axi_rd(REG_CONFIG, {24'h0, CONFIG_RESET}, RESP_OKAY);
		axi_rd(REG_PREAMBLE, {24'h0, PREAMBLE_RESET}, RESP_OKAY);
		axi_wr(8'h40, 32'h1, RESP_SLVERR);
		axi_rd(8'h40, 32'h0, RESP_SLVERR);
		axi_wr(REG_MEM_PTR, 32'h0, RESP_OKAY);
		for (int i = 0; i < 16; i++) axi_wr(REG_MEM_DATA, {24'h0, mv(i)}, RESP_OKAY);
		axi_wr(REG_MEM_PTR, 32'h3FF, RESP_OKAY);
		axi_wr(REG_MEM_DATA, {24'h0, mv(32'h3FF)}, RESP_OKAY);
		axi_wr(REG_MEM_PTR, 32'h3FF, RESP_OKAY);
		axi_rd(REG_MEM_DATA, {24'h0, mv(32'h3FF)}, RESP_OKAY);
	endtask : t_regs

	task automatic t_quad_off();
		qdr_host_model_inst.frame(1'b1, OP_FOUR_LANE_READ, 1'b0, 3, 32'h2, 1'b1, 8'h00, 8,
			2, pre_got, dat_got);
		chk_val({31'h0, qdr_host_model_inst.seen}, 32'h0);
	endtask : t_quad_off

	task automatic t_quad();
		for (int lc = 0; lc < 4; lc++) begin
			axi_wr(REG_CONFIG, 32'(32'h2 | lc << 2), RESP_OKAY);
			rd(1'b1, OP_FOUR_LANE_READ, 1'b0, 3, 32'(lc + 3), 1'b1, 8'h00, qd[lc]);
		end
		axi_wr(REG_CONFIG, 32'h16, RESP_OKAY); // enhanced table, same latency
		rd(1'b1, OP_FOUR_LANE_READ, 1'b0, 3, 32'h1, 1'b1, 8'h00, 4);
		axi_wr(REG_CONFIG, 32'h2, RESP_OKAY);
		rd(1'b1, OP_FOUR_LANE_READ_LONG, 1'b0, 4, 32'h0100_0005, 1'b1, 8'h00, 8);
		rd(1'b1, OP_FOUR_LANE_READ, 1'b0, 3, 32'h00FF_FFFF, 1'b1, 8'h00, 8);
		axi_wr(REG_CONFIG, 32'h3, RESP_OKAY);
		rd(1'b1, OP_FOUR_LANE_READ, 1'b0, 4, 32'h0300_0007, 1'b1, 8'h00, 8);
	endtask : t_quad

	// continuous four-lane mode entered, used, left, and cut by a short pulse
	task automatic t_cont_quad();
		axi_wr(REG_CONFIG, 32'h2, RESP_OKAY);
		rd(1'b1, OP_FOUR_LANE_READ, 1'b0, 3, 32'h5, 1'b1, 8'hA5, 8);
		axi_rd(REG_STATUS, 32'hA5 << STS_MODE_LO | 32'h1 << STS_CONT_QUAD, RESP_OKAY);
		rd(1'b0, OP_FOUR_LANE_READ, 1'b0, 3, 32'h9, 1'b1, 8'h00, 8);
		rd(1'b1, OP_FOUR_LANE_READ, 1'b0, 3, 32'h1, 1'b1, 8'hA0, 8);
		// two address cycles only, then select rises before any mode byte
		qdr_host_model_inst.frame(1'b0, 8'h00, 1'b0, 1, 32'hFF, 1'b0, 8'h00, 0, 0, pre_got,
			dat_got);
		rd(1'b1, OP_FOUR_LANE_READ, 1'b0, 3, 32'h4, 1'b1, 8'h00, 8);
	endtask : t_cont_quad

	// plain table, six dummy cycles, preamble on, pause held low after the opcode
	task automatic t_ddr();
		axi_wr(REG_CONFIG, 32'h20, RESP_OKAY);
		fork
			rd(1'b1, OP_DDR_FAST_READ, 1'b1, 3, 32'h6, 1'b0, 8'h00, 6);
			begin
				repeat (80) @(posedge aclk);
				pause_n <= 1'b0;
			end
		join
		chk_val({24'h0, pre_got}, {24'h0, PREAMBLE_RESET});
		@(posedge aclk);
		pause_n <= 1'b1;
		axi_wr(REG_PREAMBLE, 32'hC9, RESP_OKAY);
		rd(1'b1, OP_DDR_FAST_READ_LONG, 1'b1, 4, 32'h0200_0008, 1'b0, 8'h00, 6);
		chk_val({24'h0, pre_got}, 32'hC9);
	endtask : t_ddr

	// enhanced table: complementary modes keep continuous, others leave it
	task automatic t_ddr_cont();
		axi_wr(REG_CONFIG, 32'h10, RESP_OKAY);
		rd(1'b1, OP_DDR_FAST_READ, 1'b1, 3, 32'h2, 1'b1, 8'hA5, 8);
		axi_rd(REG_STATUS, 32'hA5 << STS_MODE_LO | 32'h1 << STS_CONT_DDR, RESP_OKAY);
		rd(1'b0, OP_DDR_FAST_READ, 1'b1, 3, 32'h7, 1'b1, 8'h5A, 8);
		rd(1'b0, OP_DDR_FAST_READ, 1'b1, 3, 32'hA, 1'b1, 8'h0F, 8);
		rd(1'b0, OP_DDR_FAST_READ, 1'b1, 3, 32'h3, 1'b1, 8'hA4, 8);
		rd(1'b1, OP_DDR_FAST_READ, 1'b1, 3, 32'h8, 1'b1, 8'h00, 8);
	endtask : t_ddr_cont

	// time-zero values, reset for two edges, then the scenarios in turn
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, cyc, err_total, tests_run} = '0;
		pause_n = 1'b1;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_quad_off();
		t_quad();
		t_cont_quad();
		t_ddr();
		t_ddr_cont();
		wrap_up();
	end
endmodule : test_quad_io_and_ddr_read_engine

bind qdr_read_engine qdr_read_engine_assertions qdr_read_engine_assertions_inst (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rvalid, .rready, .sck, .chip_select_n, .quad_data_out,
	.quad_data_oe
);
`default_nettype wire
